// file: spb_regs.vh
`ifndef SPB_REGS_VH
`define SPB_REGS_VH

// Register byte offsets
`define SPB_A_PMODE    6'h00
`define SPB_A_PWD_LO   6'h04
`define SPB_A_PWD_HI   6'h08
`define SPB_A_KEY_LO   6'h0c
`define SPB_A_KEY_HI   6'h10
`define SPB_A_CMD      6'h14
`define SPB_A_CFG1     6'h18
`define SPB_A_CFG3     6'h1c
`define SPB_A_LOCK     6'h20
`define SPB_A_PACC     6'h24
`define SPB_A_DACC     6'h28
`define SPB_A_BOOT     6'h2c
`define SPB_A_ECNT     6'h30
`define SPB_A_IRQ_STS  6'h34
`define SPB_A_IRQ_MSK  6'h38

// Protection mode bit positions (0 = feature enabled)
`define SPB_PM_PRM     0
`define SPB_PM_PER     1
`define SPB_PM_PWD     2
`define SPB_PM_OTP     3
`define SPB_PM_DYB     4
`define SPB_PM_RDP     5
`define SPB_PM_RST     16'hffff
`define SPB_PWD_RST    64'hffffffffffffffff
`define SPB_PWD_HIDDEN 32'h00000000

// Config register one / three masks
`define SPB_C1_TB      5
`define SPB_C1_PWDLOCK 8'h03
`define SPB_C1_PERLOCK 8'h8b
`define SPB_C3_PERLOCK 8'hf7
`define SPB_CFG_RST    8'h00

// Boot config fields
`define SPB_BT_EN      0
`define SPB_BT_DLY_LO  1
`define SPB_BT_DLY_HI  8
`define SPB_BT_ADR_LO  9
`define SPB_BT_ADR_HI  31
`define SPB_BT_RST     32'h00000000

// Command register: opcode [3:0], sector [11:8]
`define SPB_CMD_OP_HI  3
`define SPB_CMD_SC_LO  8
`define SPB_CMD_SC_HI  11
`define SPB_OP_PREAD   4'h1
`define SPB_OP_DREAD   4'h2
`define SPB_OP_PPROG   4'h3
`define SPB_OP_PERASE  4'h4
`define SPB_OP_DPROT   4'h5
`define SPB_OP_DUNPROT 4'h6
`define SPB_OP_UNLOCK  4'h7
`define SPB_OP_PLOCK   4'h8

// Sector geometry, access codes, interrupt events
`define SPB_SECTS      16
`define SPB_SECT_TOP   4'hf
`define SPB_SECT_BOT   4'h0
`define SPB_ACC_OPEN   8'hff
`define SPB_ACC_PROT   8'h00
`define SPB_CORRUPT    23
`define SPB_IRQ_W      4
`define SPB_EV_REFUSE  0
`define SPB_EV_BADPWD  1
`define SPB_EV_BOOT    2
`define SPB_EV_CORRUPT 3

`endif

// file: spb_top.v
`default_nettype none
`include "spb_regs.vh"

module spb_top (
    input  wire        clock_i,
    input  wire        arst_n_i,
    input  wire        ce_i,
    input  wire [5:0]  avm_address_i,
    input  wire        avm_read_i,
    input  wire        avm_write_i,
    input  wire [31:0] avm_writedata_i,
    input  wire [3:0]  avm_byteenable_i,
    output reg  [31:0] avm_readdata_o,
    output reg         avm_waitrequest_o,
    input  wire        sclk_i,
    input  wire [3:0]  acc_sector_i,
    input  wire        erase_done_i,
    input  wire        count_corrupt_i,
    input  wire [3:0]  erase_sector_i,
    output reg         read_allow_o,
    output reg         write_allow_o,
    output reg         boot_start_o,
    output reg  [22:0] boot_start_address_o,
    output reg         irq_o
);

    // Boot sequencer states
    localparam [1:0] BT_IDLE = 2'b00;
    localparam [1:0] BT_WAIT = 2'b01;
    localparam [1:0] BT_DONE = 2'b10;

    // Byte-lane merge shared by every 32-bit register write
    function [31:0] spb_be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer      k;
        begin
            spb_be_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    spb_be_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // Readback code for one protection bit
    function [7:0] spb_acc_code;
        input bit_v;
        begin
            spb_acc_code = bit_v ? `SPB_ACC_OPEN : `SPB_ACC_PROT;
        end
    endfunction

    reg  [15:0] pmode_q;
    reg  [63:0] pwd_q;
    reg  [63:0] key_q;
    reg  [7:0]  cfg1_q;
    reg  [7:0]  cfg3_q;
    reg         lock_q;
    reg         unlocked_q;
    reg  [7:0]  pacc_q;
    reg  [7:0]  dacc_q;
    reg  [31:0] boot_q;
    reg  [3:0]  sel_q;
    reg  [15:0] ppb_q;
    reg  [15:0] dyb_q;
    reg  [22:0] ecnt_q [0:15];
    reg  [15:0] corrupt_q;
    reg  [3:0]  sts_q;
    reg  [3:0]  msk_q;
    reg         init_q;
    reg  [1:0]  bt_state_q;
    reg  [7:0]  bt_cnt_q;
    reg         sclk_s1_q;
    reg         sclk_s2_q;
    reg         sclk_s3_q;
    reg  [31:0] rd_val;
    reg  [3:0]  ev;
    integer     i;

    // Request taken when waitrequest is still high; answer next cycle
    wire        acc_req  = ce_i & avm_waitrequest_o & (avm_read_i | avm_write_i);
    wire        wr_req   = acc_req & avm_write_i;
    wire [31:0] wd       = avm_writedata_i;
    wire        pwd_off  = pmode_q[`SPB_PM_PWD];
    wire        per_off  = pmode_q[`SPB_PM_PER];
    wire        cmd_go   = wr_req & (avm_address_i == `SPB_A_CMD);
    wire [3:0]  cmd_op   = wd[`SPB_CMD_OP_HI:0];
    wire [3:0]  cmd_sc   = wd[`SPB_CMD_SC_HI:`SPB_CMD_SC_LO];
    wire        key_ok   = (key_q == pwd_q);
    wire        sclk_rise = sclk_s2_q & ~sclk_s3_q;
    wire        tb_top   = cfg1_q[`SPB_C1_TB];

    // Persistent bits change only with lock set, permanent protect off,
    // and password mode off or unlocked
    wire ppb_mod_ok = lock_q & pmode_q[`SPB_PM_PRM]
                      & (pwd_off | unlocked_q);
    wire ppb_erase_ok = ppb_mod_ok & pmode_q[`SPB_PM_OTP];

    // Read-password lock holds until the right password arrives
    wire rd_locked = ~pmode_q[`SPB_PM_RDP] & ~pwd_off & ~unlocked_q;
    // The sector that stays readable under the lock is a full sector
    // number. A one-bit net here would compare every sector against 0 or 1,
    // so the top sector could never be the free one.
    wire [3:0] free_sect = tb_top ? `SPB_SECT_TOP : `SPB_SECT_BOT;

    // Mask of config-one bits a write may change
    wire [7:0] c1_mask = (pwd_off ? 8'hff : `SPB_C1_PWDLOCK)
                       & (per_off ? 8'hff : `SPB_C1_PERLOCK);
    wire [7:0] c3_mask = per_off ? 8'hff : `SPB_C3_PERLOCK;
    wire       pm_wr_ok = pwd_off & per_off;

    // Link clock is asynchronous: two stages, then a third for edges
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
        end else if (ce_i) begin
            sclk_s1_q <= sclk_i;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end

    // Bus handshake: one wait-free cycle per request.
    // Waitrequest is low for exactly one cycle, so a master that holds its
    // strobe across that edge cannot start a second transfer by accident.
    // The cost is one idle cycle between back-to-back requests.
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avm_waitrequest_o <= 1'b1;
            avm_readdata_o    <= 32'h00000000;
        end else if (ce_i) begin
            avm_waitrequest_o <= ~acc_req;
            if (acc_req && avm_read_i) begin
                avm_readdata_o <= rd_val;
            end
        end
    end

    // Readback mux; unmapped offsets read zero
    always @* begin
        rd_val = 32'h00000000;
        case (avm_address_i)
            `SPB_A_PMODE:   rd_val = {16'h0000, pmode_q};
            `SPB_A_PWD_LO:  rd_val = pwd_off ? pwd_q[31:0] : `SPB_PWD_HIDDEN;
            `SPB_A_PWD_HI:  rd_val = pwd_off ? pwd_q[63:32] : `SPB_PWD_HIDDEN;
            `SPB_A_CMD:     rd_val = {20'h00000, sel_q, 8'h00};
            `SPB_A_CFG1:    rd_val = {24'h000000, cfg1_q};
            `SPB_A_CFG3:    rd_val = {24'h000000, cfg3_q};
            `SPB_A_LOCK:    rd_val = {31'h00000000, lock_q};
            `SPB_A_PACC:    rd_val = {24'h000000, pacc_q};
            `SPB_A_DACC:    rd_val = {24'h000000, dacc_q};
            `SPB_A_BOOT:    rd_val = boot_q;
            `SPB_A_ECNT:    rd_val = {8'h00, corrupt_q[sel_q], ecnt_q[sel_q]};
            `SPB_A_IRQ_STS: rd_val = {28'h0000000, sts_q};
            `SPB_A_IRQ_MSK: rd_val = {28'h0000000, msk_q};
            default:        rd_val = 32'h00000000;
        endcase
    end

    // Non-volatile mode and password words: program toward zero only
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pmode_q <= `SPB_PM_RST;
            pwd_q   <= `SPB_PWD_RST;
        end else if (ce_i && wr_req) begin
            if (avm_address_i == `SPB_A_PMODE && pm_wr_ok) begin
                pmode_q <= pmode_q & wd[15:0];
            end
            if (avm_address_i == `SPB_A_PWD_LO && pwd_off) begin
                pwd_q[31:0] <= pwd_q[31:0] & spb_be_merge(32'hffffffff, wd,
                                                          avm_byteenable_i);
            end
            if (avm_address_i == `SPB_A_PWD_HI && pwd_off) begin
                pwd_q[63:32] <= pwd_q[63:32] & spb_be_merge(32'hffffffff, wd,
                                                            avm_byteenable_i);
            end
        end
    end

    // Plain configuration words with their protection masks
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_q  <= 64'h0000000000000000;
            cfg1_q <= `SPB_CFG_RST;
            cfg3_q <= `SPB_CFG_RST;
            boot_q <= `SPB_BT_RST;
            msk_q  <= 4'h0;
        end else if (ce_i && wr_req) begin
            case (avm_address_i)
                `SPB_A_KEY_LO:  key_q[31:0]  <= spb_be_merge(key_q[31:0], wd,
                                                             avm_byteenable_i);
                `SPB_A_KEY_HI:  key_q[63:32] <= spb_be_merge(key_q[63:32], wd,
                                                             avm_byteenable_i);
                `SPB_A_CFG1:    cfg1_q <= (cfg1_q & ~c1_mask) | (wd[7:0] & c1_mask);
                `SPB_A_CFG3:    cfg3_q <= (cfg3_q & ~c3_mask) | (wd[7:0] & c3_mask);
                `SPB_A_BOOT:    boot_q <= spb_be_merge(boot_q, wd, avm_byteenable_i);
                `SPB_A_IRQ_MSK: msk_q  <= wd[`SPB_IRQ_W-1:0];
                default:        msk_q  <= msk_q;
            endcase
        end
    end

    // Sector protection bits, lock, unlock and access readback.
    // The first enabled cycle after reset loads the power-up state,
    // because an async reset may only load constants.
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            init_q     <= 1'b0;
            lock_q     <= 1'b1;
            unlocked_q <= 1'b0;
            ppb_q      <= 16'hffff;
            dyb_q      <= 16'hffff;
            pacc_q     <= `SPB_ACC_OPEN;
            dacc_q     <= `SPB_ACC_OPEN;
            sel_q      <= 4'h0;
        end else if (ce_i) begin
            if (!init_q) begin
                init_q <= 1'b1;
                lock_q <= pwd_off;
                if (!pmode_q[`SPB_PM_DYB]) begin
                    dyb_q <= 16'h0000;
                end
            end else if (wr_req && avm_address_i == `SPB_A_LOCK) begin
                lock_q <= lock_q & wd[0];
            end else if (cmd_go) begin
                sel_q <= cmd_sc;
                case (cmd_op)
                    `SPB_OP_PREAD:  pacc_q <= spb_acc_code(ppb_q[cmd_sc]);
                    `SPB_OP_DREAD:  dacc_q <= spb_acc_code(dyb_q[cmd_sc]);
                    `SPB_OP_PPROG: begin
                        if (ppb_mod_ok) begin
                            ppb_q[cmd_sc] <= 1'b0;
                        end
                    end
                    `SPB_OP_PERASE: begin
                        if (ppb_erase_ok) begin
                            ppb_q <= 16'hffff;
                        end
                    end
                    `SPB_OP_DPROT:   dyb_q[cmd_sc] <= 1'b0;
                    `SPB_OP_DUNPROT: dyb_q[cmd_sc] <= 1'b1;
                    `SPB_OP_UNLOCK: begin
                        if (key_ok) begin
                            unlocked_q <= 1'b1;
                            lock_q     <= 1'b1;
                        end
                    end
                    `SPB_OP_PLOCK:  lock_q <= 1'b0;
                    default:        sel_q  <= cmd_sc;
                endcase
            end
        end
    end

    // Event pulses for the interrupt status
    always @* begin
        ev = 4'h0;
        if (cmd_go && init_q) begin
            if ((cmd_op == `SPB_OP_PPROG && !ppb_mod_ok) ||
                (cmd_op == `SPB_OP_PERASE && !ppb_erase_ok)) begin
                ev[`SPB_EV_REFUSE] = 1'b1;
            end
            if (cmd_op == `SPB_OP_UNLOCK && !key_ok) begin
                ev[`SPB_EV_BADPWD] = 1'b1;
            end
        end
        if (wr_req && avm_address_i == `SPB_A_PMODE && !pm_wr_ok) begin
            ev[`SPB_EV_REFUSE] = 1'b1;
        end
        ev[`SPB_EV_BOOT]    = boot_start_o;
        ev[`SPB_EV_CORRUPT] = ce_i & count_corrupt_i;
    end

    // Sticky status, write one to clear; a new event beats the clear.
    // Software that clears a bit while the same event fires sees the bit
    // again, so no event can be lost between a read and its clear.
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sts_q <= 4'h0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_req && avm_address_i == `SPB_A_IRQ_STS) begin
                sts_q <= (sts_q & ~wd[`SPB_IRQ_W-1:0]) | ev;
            end else begin
                sts_q <= sts_q | ev;
            end
            irq_o <= |(sts_q & msk_q);
        end
    end

    // Erase counters per sector; corruption resets count and wins
    // over a same-cycle erase of the same sector.
    // The counter wraps silently at its full width; the array side is
    // trusted never to report that many erases of one sector.
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (i = 0; i < `SPB_SECTS; i = i + 1) begin
                ecnt_q[i] <= 23'h000000;
            end
            corrupt_q <= 16'h0000;
        end else if (ce_i) begin
            if (erase_done_i) begin
                ecnt_q[erase_sector_i]    <= ecnt_q[erase_sector_i] + 23'h000001;
                corrupt_q[erase_sector_i] <= 1'b0;
            end
            if (count_corrupt_i) begin
                ecnt_q[erase_sector_i]    <= 23'h000000;
                corrupt_q[erase_sector_i] <= 1'b1;
            end
        end
    end

    // Access permission for the array engine, registered
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_allow_o  <= 1'b0;
            write_allow_o <= 1'b0;
        end else if (ce_i) begin
            read_allow_o  <= init_q & (~rd_locked | (acc_sector_i == free_sect));
            write_allow_o <= init_q & ~rd_locked
                             & ppb_q[acc_sector_i] & dyb_q[acc_sector_i];
        end
    end

    // Boot read: after reset, count link clock edges, then start.
    // The settings are sampled only in the init cycle, while the boot word still
    // holds its reset value of zero, so the boot read stays disabled and a written boot word never takes effect.
    // The count uses the sampled link clock, so it is only exact while
    // the link clock stays well below half the core clock.
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bt_state_q           <= BT_IDLE;
            bt_cnt_q             <= 8'h00;
            boot_start_o         <= 1'b0;
            boot_start_address_o <= 23'h000000;
        end else if (ce_i) begin
            boot_start_o <= 1'b0;
            case (bt_state_q)
                BT_IDLE: begin
                    if (!init_q) begin
                        boot_start_address_o <= boot_q[`SPB_BT_ADR_HI:`SPB_BT_ADR_LO];
                        bt_cnt_q <= boot_q[`SPB_BT_DLY_HI:`SPB_BT_DLY_LO];
                        if (boot_q[`SPB_BT_EN]) begin
                            bt_state_q <= BT_WAIT;
                        end else begin
                            bt_state_q <= BT_DONE;
                        end
                    end
                end
                BT_WAIT: begin
                    if (bt_cnt_q == 8'h00) begin
                        boot_start_o <= 1'b1;
                        bt_state_q   <= BT_DONE;
                    end else if (sclk_rise) begin
                        bt_cnt_q <= bt_cnt_q - 8'h01;
                    end
                end
                BT_DONE: bt_state_q <= BT_DONE;
                default: bt_state_q <= BT_DONE;
            endcase
        end
    end

endmodule // spb_top

`default_nettype wire

// file: spb_top_properties.sv
`default_nettype none
`include "spb_regs.vh"
module spb_top_properties (
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    input wire logic        ce_i,
    input wire logic [5:0]  avm_address_i,
    input wire logic        avm_read_i,
    input wire logic        avm_write_i,
    input wire logic [31:0] avm_writedata_i,
    input wire logic [31:0] avm_readdata_o,
    input wire logic        avm_waitrequest_o,
    input wire logic [3:0]  acc_sector_i,
    input wire logic        read_allow_o,
    input wire logic        boot_start_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        take;
    logic        rd_take;
    logic [15:0] pm_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // Request accepted by the slave at this edge
    assign take    = ce_i && avm_waitrequest_o && (avm_read_i || avm_write_i);
    assign rd_take = take && avm_read_i;
    // Mode shadow: writes only clear bits, and only while neither lock is set
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pm_q <= `SPB_PM_RST;
        end else if (take && avm_write_i && avm_address_i == `SPB_A_PMODE
                     && pm_q[`SPB_PM_PWD] && pm_q[`SPB_PM_PER]) begin
            pm_q <= pm_q & avm_writedata_i[15:0];
        end
    end
    wait_answer_a:
        assert property (take |=> !avm_waitrequest_o) else $error("request not answered");
    wait_single_a:
        assert property (!avm_waitrequest_o |=> avm_waitrequest_o) else $error("answer too long");
    mode_read_a:
        assert property (rd_take && avm_address_i == `SPB_A_PMODE
            |=> avm_readdata_o == {16'h0000, pm_q}) else $error("mode register value wrong");
    pwd_hidden_a:
        assert property (rd_take && !pm_q[`SPB_PM_PWD] && (avm_address_i == `SPB_A_PWD_LO
            || avm_address_i == `SPB_A_PWD_HI) |=> avm_readdata_o == `SPB_PWD_HIDDEN)
            else $error("password visible in password mode");
    pacc_code_a:
        assert property (rd_take && avm_address_i == `SPB_A_PACC
            |=> avm_readdata_o == 32'h000000ff || avm_readdata_o == 32'h00000000)
            else $error("persistent access code not ff or 00");
    dacc_code_a:
        assert property (rd_take && avm_address_i == `SPB_A_DACC
            |=> avm_readdata_o == 32'h000000ff || avm_readdata_o == 32'h00000000)
            else $error("dynamic access code not ff or 00");
    ecnt_width_a:
        assert property (rd_take && avm_address_i == `SPB_A_ECNT
            |=> avm_readdata_o[31:24] == 8'h00) else $error("erase count too wide");
    read_block_a:
        assert property (!$past(pm_q[`SPB_PM_RDP]) && !$past(pm_q[`SPB_PM_PWD])
            && $past(acc_sector_i) != `SPB_SECT_TOP && $past(acc_sector_i) != `SPB_SECT_BOT
            |-> !read_allow_o) else $error("locked sector readable");
    boot_off_a:
        assert property (!boot_start_o) else $error("boot read started while disabled");
    cover property (take && avm_write_i);
    cover property (!read_allow_o);
    cover property (rd_take && avm_address_i == `SPB_A_PACC);
endmodule // spb_top_properties
bind spb_top spb_top_properties i_spb_top_properties (.clock_i, .arst_n_i, .ce_i,
    .avm_address_i, .avm_read_i, .avm_write_i, .avm_writedata_i, .avm_readdata_o,
    .avm_waitrequest_o, .acc_sector_i, .read_allow_o, .boot_start_o);
`default_nettype wire

// file: spb_array_model.sv
`default_nettype none
module spb_array_model (
    input  wire logic  clock_i,
    output logic       sclk_o,
    output logic       erase_done_o,
    output logic       count_corrupt_o,
    output logic [3:0] erase_sector_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Link clock offset so its edges never meet the core clock
    initial begin
        sclk_o          = 1'b0;
        erase_done_o    = 1'b0;
        count_corrupt_o = 1'b0;
        erase_sector_o  = 4'h0;
        #7;
        forever #160 sclk_o = ~sclk_o;
    end
    // One-cycle array event; the sector line is scrambled once the pulse ends
    task automatic pulse(input logic bad, input logic [3:0] sec);
        erase_sector_o  <= sec;
        erase_done_o    <= !bad;
        count_corrupt_o <= bad;
        @(posedge clock_i);
        erase_done_o    <= 1'b0;
        count_corrupt_o <= 1'b0;
        erase_sector_o  <= ~sec;
        @(posedge clock_i);
    endtask
endmodule // spb_array_model
`default_nettype wire

// file: tb.sv
`default_nettype none
`include "spb_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i  = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [5:0]  adr      = 6'h00;
    logic        rd_s     = 1'b0;
    logic        wr_s     = 1'b0;
    logic [31:0] wdat     = 32'h0;
    logic [3:0]  acc      = 4'h0;
    logic [3:0]  s;
    logic [3:0]  t;
    wire  [31:0] rdat;
    wire  [22:0] boot_adr;
    wire  [3:0]  ers_sec;
    wire         wreq, rd_ok, wr_ok, boot_go, irq, sclk, ers, cor;
    logic [31:0] exp_q[$];
    int          bad_count    = 0;
    int          total_checks = 0;
    always #20 clock_i = ~clock_i;
    spb_top i_spb_top (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
        .avm_address_i(adr), .avm_read_i(rd_s), .avm_write_i(wr_s),
        .avm_writedata_i(wdat), .avm_byteenable_i(4'hf), .avm_readdata_o(rdat),
        .avm_waitrequest_o(wreq), .sclk_i(sclk), .acc_sector_i(acc),
        .erase_done_i(ers), .count_corrupt_i(cor), .erase_sector_i(ers_sec),
        .read_allow_o(rd_ok), .write_allow_o(wr_ok), .boot_start_o(boot_go),
        .boot_start_address_o(boot_adr), .irq_o(irq));
    spb_array_model i_spb_array_model (.clock_i(clock_i), .sclk_o(sclk),
        .erase_done_o(ers), .count_corrupt_o(cor), .erase_sector_o(ers_sec));
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; one idle edge keeps drives apart
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr  <= a;
        wdat <= d;
        wr_s <= w;
        rd_s <= !w;
        do begin
            @(posedge clock_i);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        if (n >= 100) begin
            bad_count++;
            summarize();
        end
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic op(input logic [3:0] c, input logic [3:0] sec);
        wr(`SPB_A_CMD, {20'h0, sec, 4'h0, c});
    endtask
    // Allow levels trail the sector select by a cycle, so let it settle
    task automatic allow(input logic [3:0] sec, input logic r, input logic w);
        acc <= sec;
        repeat (3) @(posedge clock_i);
        cmp({31'h0, rd_ok}, {31'h0, r});
        cmp({31'h0, wr_ok}, {31'h0, w});
    endtask
    task automatic reset_dut;
        arst_n_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
    endtask
    // Read results are matched against the oldest note when the answer comes
    always @(posedge clock_i) begin
        if (arst_n_i && rd_s && wreq === 1'b0 && exp_q.size() > 0) begin
            cmp(rdat, exp_q.pop_front());
        end
    end
    // Hang guard
    initial begin
        #400us;
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(60332));
        s = 4'($urandom_range(15, 0));
        t = s ^ 4'h1;
        reset_dut();
        rd(`SPB_A_PMODE, 32'h0000ffff);
        rd(`SPB_A_PWD_LO, 32'hffffffff);
        rd(`SPB_A_LOCK, 32'h1);
        rd(`SPB_A_DACC, 32'hff);
        rd(`SPB_A_BOOT, 32'h0);
        cmp({9'h0, boot_adr}, 32'h0);
        cmp({31'h0, boot_go}, 32'h0);
        op(`SPB_OP_PPROG, s);
        op(`SPB_OP_PREAD, s);
        rd(`SPB_A_PACC, 32'h0);
        op(`SPB_OP_PREAD, t);
        rd(`SPB_A_PACC, 32'hff);
        allow(s, 1'b1, 1'b0);
        op(`SPB_OP_PERASE, s);
        op(`SPB_OP_PREAD, s);
        rd(`SPB_A_PACC, 32'hff);
        op(`SPB_OP_DPROT, t);
        op(`SPB_OP_DREAD, t);
        rd(`SPB_A_DACC, 32'h0);
        allow(t, 1'b1, 1'b0);
        op(`SPB_OP_DUNPROT, t);
        op(`SPB_OP_DREAD, t);
        rd(`SPB_A_DACC, 32'hff);
        allow(t, 1'b1, 1'b1);
        // Erase counting, corruption and the interrupt path
        wr(`SPB_A_IRQ_MSK, 32'hf);
        op(`SPB_OP_PREAD, 4'h2);
        repeat (3) i_spb_array_model.pulse(1'b0, 4'h2);
        rd(`SPB_A_ECNT, 32'h3);
        i_spb_array_model.pulse(1'b1, 4'h2);
        rd(`SPB_A_ECNT, 32'h00800000);
        cmp({31'h0, irq}, 32'h1);
        rd(`SPB_A_IRQ_STS, 32'h8);
        wr(`SPB_A_IRQ_STS, 32'h8);
        cmp({31'h0, irq}, 32'h0);
        i_spb_array_model.pulse(1'b0, 4'h2);
        rd(`SPB_A_ECNT, 32'h1);
        op(`SPB_OP_PREAD, 4'h3);
        rd(`SPB_A_ECNT, 32'h0);
        // Cleared lock refuses programming until the next reset or an unlock with the matching password
        op(`SPB_OP_PLOCK, 4'h0);
        rd(`SPB_A_LOCK, 32'h0);
        op(`SPB_OP_PPROG, s);
        op(`SPB_OP_PREAD, s);
        rd(`SPB_A_PACC, 32'hff);
        rd(`SPB_A_IRQ_STS, 32'h1);
        cmp({31'h0, irq}, 32'h1);
        wr(`SPB_A_IRQ_MSK, 32'h0);
        cmp({31'h0, irq}, 32'h0);
        reset_dut();
        rd(`SPB_A_LOCK, 32'h1);
        // One-time programmable and permanent modes
        wr(`SPB_A_PMODE, 32'h0000fff7);
        op(`SPB_OP_PPROG, s);
        op(`SPB_OP_PERASE, s);
        op(`SPB_OP_PREAD, s);
        rd(`SPB_A_PACC, 32'h0);
        wr(`SPB_A_PMODE, 32'h0000fffe);
        rd(`SPB_A_PMODE, 32'h0000fff6);
        op(`SPB_OP_PPROG, t);
        op(`SPB_OP_PREAD, t);
        rd(`SPB_A_PACC, 32'hff);
        // Register protection
        reset_dut();
        wr(`SPB_A_PMODE, 32'h0000fffd);
        wr(`SPB_A_PMODE, 32'h0000ffc0);
        rd(`SPB_A_PMODE, 32'h0000fffd);
        wr(`SPB_A_CFG1, 32'hff);
        rd(`SPB_A_CFG1, 32'h8b);
        wr(`SPB_A_CFG3, 32'hff);
        rd(`SPB_A_CFG3, 32'hf7);
        // Password and read-password modes
        reset_dut();
        wr(`SPB_A_PWD_LO, 32'h12345678);
        wr(`SPB_A_PMODE, 32'h0000ffdb);
        rd(`SPB_A_PWD_LO, 32'h0);
        wr(`SPB_A_PWD_HI, 32'h0);
        rd(`SPB_A_PWD_HI, 32'h0);
        wr(`SPB_A_PMODE, 32'h0000ffc0);
        rd(`SPB_A_PMODE, 32'h0000ffdb);
        wr(`SPB_A_CFG1, 32'hfc);
        rd(`SPB_A_CFG1, 32'h0);
        allow(4'h7, 1'b0, 1'b0);
        allow(4'h0, 1'b1, 1'b0);
        op(`SPB_OP_PPROG, s);
        op(`SPB_OP_PREAD, s);
        rd(`SPB_A_PACC, 32'hff);
        wr(`SPB_A_KEY_LO, 32'h0);
        op(`SPB_OP_UNLOCK, 4'h0);
        rd(`SPB_A_IRQ_STS, 32'h3);
        reset_dut();
        rd(`SPB_A_PMODE, 32'h0000ffff);
        summarize();
    end
endmodule // tb
`default_nettype wire
